// file: hdl/ipc_map.vh
// Constants for the inrush peak capture sequencer
// Summary of operation
// R1 - Every sample checked against stored peaks
// R2 - Latest and highest sets, positive and negative
// R3 - Half-cycle peak above twice previous cycle
// R4 - New event overwrites latest peaks unconditionally
// R5 - Highest peaks survive new switching events
// R6 - Start key clears both peak sets
// R7 - Inrush entry selects 400A, disables autorange
// R8 - Up/down keys step range in inrush
// R9 - Inrush trigger source fires one trace
// R10 - Manual setting leaves relay to load switch
// R11 - Sequencer cycles relay, synchronised to supply
// R12 - Durations in cycles, 4 to 65535
// R13 - Phases measured from rising zero crossing
// R14 - Phase entry -999..999, stored 0..359
// R15 - Enter commits, cancel restores old value
// R16 - Digit key starts entry directly
// R17 - Phase reduced modulo 360, non-negative
// R18 - On/off intervals alternate, switch at phase
`ifndef IPC_MAP_VH
`define IPC_MAP_VH

`define IPC_RANGE_MAX   2'h3
`define IPC_RANGE_MIN   2'h0
`define IPC_DUR_MIN     17'h00004
`define IPC_DUR_MAX     17'h0ffff
`define IPC_DEG_FULL    10'h168
`define IPC_DEG_TWO     10'h2d0
`define IPC_DEG_TOP     9'h167
`define IPC_DEG_STEP    24'h000168
`define IPC_ON_RST      16'h0032
`define IPC_OFF_RST     16'h00fa
`define IPC_PH_RST      9'h000
`define IPC_FLD_ON_T    2'h0
`define IPC_FLD_OFF_T   2'h1
`define IPC_FLD_ON_PH   2'h2
`define IPC_FLD_OFF_PH  2'h3
`define IPC_DIG_DUR     3'h5
`define IPC_DIG_PH      3'h3

`endif

// file: hdl/ipc_sequencer.v
// Inrush peak capture, re-trigger detection and relay sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ipc_map.vh"

module ipc_sequencer
(
  input  wire               CORE_CLK,
  input  wire               RST_N,
  input  wire               SAMPLE_VALID,
  input  wire signed [15:0] SAMPLE,
  input  wire               ZC_RISE,
  input  wire               ZC_FALL,
  input  wire               START_KEY,
  input  wire               MODE_INRUSH,
  input  wire               RANGE_UP,
  input  wire               RANGE_DN,
  input  wire               TRIG_INRUSH,
  input  wire               LOAD_SEQ,
  input  wire               LOAD_SW,
  input  wire        [1:0]  FIELD_SEL,
  input  wire               KEY_DIGIT,
  input  wire        [3:0]  KEY_VAL,
  input  wire               KEY_MINUS,
  input  wire               KEY_ENTER,
  input  wire               KEY_CANCEL,
  output reg  signed [15:0] LAT_POS,
  output reg  signed [15:0] LAT_NEG,
  output reg  signed [15:0] HI_POS,
  output reg  signed [15:0] HI_NEG,
  output reg         [1:0]  RANGE_SEL,
  output reg                AUTO_RANGE_EN,
  output reg                TRACE_TRIG,
  output reg                RELAY_ON,
  output reg         [15:0] ON_CYCLES,
  output reg         [15:0] OFF_CYCLES,
  output reg         [8:0]  ON_PHASE,
  output reg         [8:0]  OFF_PHASE,
  output reg                ENTRY_ACTIVE
);

  localparam [4:0] S_IDLE   = 5'h01;
  localparam [4:0] S_ON_PH  = 5'h02;
  localparam [4:0] S_ON_CNT = 5'h04;
  localparam [4:0] S_OFF_PH = 5'h08;
  localparam [4:0] S_OFF_CN = 5'h10;

  reg        [15:0] hc_pk_q;
  reg        [15:0] h1_pk_q;
  reg        [15:0] prev_cyc_q;
  reg               trig_done_q;
  reg               mode_q;
  reg               ph_ok_q;
  reg        [23:0] per_cnt_q;
  reg        [23:0] period_q;
  reg        [23:0] acc_q;
  reg        [8:0]  deg_q;
  reg        [4:0]  state_q;
  reg        [4:0]  state_d;
  reg        [15:0] cyc_q;
  reg        [16:0] buf_q;
  reg               neg_q;
  reg        [2:0]  ndig_q;
  reg        [1:0]  fld_q;

  // Unsigned magnitude, so a full-scale negative sample cannot overflow
  wire        [15:0] mag     = SAMPLE[15] ? (~SAMPLE + 16'h0001) : SAMPLE;
  // Only a qualified sample may raise the half-cycle peak
  wire               hc_up   = SAMPLE_VALID & (mag > hc_pk_q);
  wire        [15:0] hc_new  = hc_up ? mag : hc_pk_q;
  wire               half_end = ZC_RISE | ZC_FALL;
  wire               retrig   = SAMPLE_VALID & ~trig_done_q &
                                ({1'b0, mag} > {prev_cyc_q, 1'b0});
  wire               seq_en   = MODE_INRUSH & LOAD_SEQ;
  wire               is_ph    = fld_q[1];
  wire        [23:0] acc_inc  = acc_q + `IPC_DEG_STEP;
  wire        [16:0] buf_x10  = {buf_q[13:0], 3'b000} + {buf_q[15:0], 1'b0};

  // Fold a 0..999 magnitude into 0..359, negatives wrapped upward
  function [8:0] reduce_phase;
    input [9:0] m;
    input       n;
    reg   [9:0] r;
    // Entries stop at 999, so two folds at most
    begin
      r = m;
      if (r >= `IPC_DEG_TWO)
        r = r - `IPC_DEG_TWO;
      else if (r >= `IPC_DEG_FULL)
        r = r - `IPC_DEG_FULL;
      if (n && (r != 10'h000))
        r = `IPC_DEG_FULL - r;
      reduce_phase = r[8:0];
    end
  endfunction

  // Peak accumulators and re-trigger detector
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      LAT_POS     <= 16'h0000;
      LAT_NEG     <= 16'h0000;
      HI_POS      <= 16'h0000;
      HI_NEG      <= 16'h0000;
      hc_pk_q     <= 16'h0000;
      h1_pk_q     <= 16'h0000;
      prev_cyc_q  <= 16'hffff;
      trig_done_q <= 1'b0;
      TRACE_TRIG  <= 1'b0;
    end
    else
    begin
      // Trace pulse follows the cycle that captured the new peak
      TRACE_TRIG <= retrig & TRIG_INRUSH & MODE_INRUSH; // R9
      if (half_end)
      begin
        // Cycle before the new half: the two halves just finished
        prev_cyc_q  <= (h1_pk_q > hc_new) ? h1_pk_q : hc_new;
        h1_pk_q     <= hc_new;
        hc_pk_q     <= 16'h0000;
        // A boundary sample that fired still counts for the new half
        trig_done_q <= retrig; // R3
      end
      else if (SAMPLE_VALID)
      begin
        hc_pk_q <= hc_new;
        if (retrig)
          trig_done_q <= 1'b1; // R3
      end
      if (START_KEY)
      begin
        LAT_POS <= 16'h0000; // R6
        LAT_NEG <= 16'h0000;
        HI_POS  <= 16'h0000;
        HI_NEG  <= 16'h0000;
      end
      else if (SAMPLE_VALID)
      begin
        if (retrig)
        begin
          // Previous latest discarded even if larger
          LAT_POS <= SAMPLE[15] ? 16'h0000 : SAMPLE; // R4
          LAT_NEG <= SAMPLE[15] ? SAMPLE : 16'h0000;
        end
        else
        begin
          if (SAMPLE > LAT_POS)
            LAT_POS <= SAMPLE; // R1
          if (SAMPLE < LAT_NEG)
            LAT_NEG <= SAMPLE; // R1
        end
        // Highest set is raised here and cleared only by the start key, never reset by events
        if (SAMPLE > HI_POS)
          HI_POS <= SAMPLE; // R2 R5
        if (SAMPLE < HI_NEG)
          HI_NEG <= SAMPLE; // R2 R5
      end
    end
  end

  // Current range control
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_q        <= 1'b0;
      RANGE_SEL     <= `IPC_RANGE_MAX;
      AUTO_RANGE_EN <= 1'b1;
    end
    else
    begin
      mode_q        <= MODE_INRUSH;
      AUTO_RANGE_EN <= ~MODE_INRUSH; // R7
      if (MODE_INRUSH && !mode_q)
        RANGE_SEL <= `IPC_RANGE_MAX; // R7
      // Up means more sensitive, a lower range index
      else if (MODE_INRUSH && RANGE_UP && (RANGE_SEL != `IPC_RANGE_MIN))
        RANGE_SEL <= RANGE_SEL - 2'h1; // R8
      else if (MODE_INRUSH && RANGE_DN && (RANGE_SEL != `IPC_RANGE_MAX))
        RANGE_SEL <= RANGE_SEL + 2'h1; // R8
    end
  end

  // Supply phase in whole degrees, restarted on each rising crossing
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      per_cnt_q <= 24'h000000;
      period_q  <= 24'hffffff;
      acc_q     <= 24'h000000;
      deg_q     <= 9'h000;
      ph_ok_q   <= 1'b0;
    end
    else if (ZC_RISE)
    begin
      per_cnt_q <= 24'h000001;
      period_q  <= per_cnt_q;
      // Degrees are trusted only once a whole period has been timed
      ph_ok_q   <= (period_q != 24'hffffff);
      acc_q     <= 24'h000000;
      deg_q     <= 9'h000; // R13
    end
    else
    begin
      if (per_cnt_q != 24'hffffff)
        per_cnt_q <= per_cnt_q + 24'h000001;
      // Fractional divider avoids a hardware divide by the period
      // At most one degree per clock: the period must be at least 360 clocks
      if (acc_inc >= period_q)
      begin
        acc_q <= acc_inc - period_q;
        if (deg_q != `IPC_DEG_TOP)
          deg_q <= deg_q + 9'h001;
      end
      else
        acc_q <= acc_inc;
    end
  end

  // Relay sequencer
  always @*
  begin
    state_d = state_q;
    case (state_q)
      // No switching until the supply phase is known
      S_IDLE:
        if (seq_en && ph_ok_q)
          state_d = S_ON_PH;
      S_ON_PH:
        if (deg_q == ON_PHASE)
          state_d = S_ON_CNT; // R13
      S_ON_CNT:
        if (ZC_RISE && (cyc_q == 16'h0001))
          state_d = S_OFF_PH; // R18
      S_OFF_PH:
        if (deg_q == OFF_PHASE)
          state_d = S_OFF_CN; // R13
      S_OFF_CN:
        if (ZC_RISE && (cyc_q == 16'h0001))
          state_d = S_ON_PH; // R18
      default:
        state_d = S_IDLE;
    endcase
    if (!seq_en)
      state_d = S_IDLE;
  end

  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q  <= S_IDLE;
      cyc_q    <= 16'h0000;
      RELAY_ON <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // Counts load at the phase match, so edits apply from the next interval
      if ((state_q == S_ON_PH) && (state_d == S_ON_CNT))
        cyc_q <= ON_CYCLES; // R11
      else if ((state_q == S_OFF_PH) && (state_d == S_OFF_CN))
        cyc_q <= OFF_CYCLES; // R11
      else if (ZC_RISE && (cyc_q != 16'h0000))
        cyc_q <= cyc_q - 16'h0001;
      // Manual setting: the relay only mirrors the panel or load switch
      if (!seq_en)
        RELAY_ON <= LOAD_SW; // R10
      else
        RELAY_ON <= (state_d == S_ON_CNT) || (state_d == S_OFF_PH); // R11
    end
  end

  // Numeric entry for durations and phases
  always @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ENTRY_ACTIVE <= 1'b0;
      buf_q        <= 17'h00000;
      neg_q        <= 1'b0;
      ndig_q       <= 3'h0;
      fld_q        <= `IPC_FLD_ON_T;
      ON_CYCLES    <= `IPC_ON_RST;
      OFF_CYCLES   <= `IPC_OFF_RST;
      ON_PHASE     <= `IPC_PH_RST;
      OFF_PHASE    <= `IPC_PH_RST;
    end
    // Cancel beats enter; stored settings are never touched by it
    else if (KEY_CANCEL)
      ENTRY_ACTIVE <= 1'b0; // R15
    else if (KEY_ENTER && ENTRY_ACTIVE)
    begin
      ENTRY_ACTIVE <= 1'b0; // R15
      // Out-of-range durations are refused, old value kept
      if (!is_ph && (buf_q >= `IPC_DUR_MIN) && (buf_q <= `IPC_DUR_MAX))
      begin
        if (fld_q == `IPC_FLD_ON_T)
          ON_CYCLES <= buf_q[15:0]; // R12
        else
          OFF_CYCLES <= buf_q[15:0]; // R12
      end
      else if (is_ph && (fld_q == `IPC_FLD_ON_PH))
        ON_PHASE <= reduce_phase(buf_q[9:0], neg_q); // R14 R17
      else if (is_ph)
        OFF_PHASE <= reduce_phase(buf_q[9:0], neg_q); // R14 R17
    end
    else if (KEY_DIGIT && (KEY_VAL <= 4'h9))
    begin
      if (!ENTRY_ACTIVE)
      begin
        // Field latched here; later selector moves only gate the minus key
        ENTRY_ACTIVE <= 1'b1; // R16
        fld_q        <= FIELD_SEL;
        neg_q        <= 1'b0;
        buf_q        <= {13'h0000, KEY_VAL};
        ndig_q       <= 3'h1;
      end
      else if (ndig_q < (is_ph ? `IPC_DIG_PH : `IPC_DIG_DUR))
      begin
        buf_q  <= buf_x10 + {13'h0000, KEY_VAL}; // R14
        ndig_q <= ndig_q + 3'h1;
      end
    end
    else if (KEY_MINUS && FIELD_SEL[1])
    begin
      if (!ENTRY_ACTIVE)
      begin
        ENTRY_ACTIVE <= 1'b1;
        fld_q        <= FIELD_SEL;
        neg_q        <= 1'b1;
        buf_q        <= 17'h00000;
        ndig_q       <= 3'h0;
      end
      else if (is_ph)
        neg_q <= ~neg_q;
    end
  end

endmodule
`default_nettype wire

// file: verification/ipc_props.sv
// Concurrent checks on the inrush peak capture sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ipc_props (
  input wire logic               CORE_CLK,
  input wire logic               RST_N,
  input wire logic               SAMPLE_VALID,
  input wire logic signed [15:0] SAMPLE,
  input wire logic               START_KEY,
  input wire logic               MODE_INRUSH,
  input wire logic               RANGE_UP,
  input wire logic               RANGE_DN,
  input wire logic               TRIG_INRUSH,
  input wire logic               LOAD_SEQ,
  input wire logic               LOAD_SW,
  input wire logic               KEY_CANCEL,
  input wire logic signed [15:0] LAT_POS,
  input wire logic signed [15:0] LAT_NEG,
  input wire logic signed [15:0] HI_POS,
  input wire logic signed [15:0] HI_NEG,
  input wire logic [1:0]         RANGE_SEL,
  input wire logic               AUTO_RANGE_EN,
  input wire logic               TRACE_TRIG,
  input wire logic               RELAY_ON,
  input wire logic [15:0]        ON_CYCLES,
  input wire logic [8:0]         ON_PHASE,
  input wire logic [8:0]         OFF_PHASE,
  input wire logic               ENTRY_ACTIVE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  start_clear_a: assert property (START_KEY |=> !(LAT_POS | LAT_NEG | HI_POS | HI_NEG))
    else $error("peaks not cleared by start");
  pos_track_a: assert property (SAMPLE_VALID && !START_KEY && SAMPLE > LAT_POS
    |=> LAT_POS == $past(SAMPLE) && HI_POS >= LAT_POS) else $error("positive peak missed");
  neg_track_a: assert property (SAMPLE_VALID && !START_KEY && SAMPLE < LAT_NEG
    |=> LAT_NEG == $past(SAMPLE) && HI_NEG <= LAT_NEG) else $error("negative peak missed");
  hi_order_a: assert property (HI_POS >= LAT_POS && HI_NEG <= LAT_NEG)
    else $error("highest below latest");
  range_entry_a: assert property ($rose(MODE_INRUSH) |=> RANGE_SEL == 2'h3 && !AUTO_RANGE_EN)
    else $error("inrush entry range wrong");
  range_up_a: assert property (MODE_INRUSH && $past(MODE_INRUSH) && RANGE_UP && !RANGE_DN
    |=> RANGE_SEL == ($past(RANGE_SEL) == 2'h0 ? 2'h0 : $past(RANGE_SEL) - 2'h1))
    else $error("range step wrong");
  trig_gate_a: assert property (TRACE_TRIG |-> $past(TRIG_INRUSH & MODE_INRUSH) ##1 !TRACE_TRIG)
    else $error("trace trigger wrong");
  relay_manual_a: assert property (!(MODE_INRUSH && LOAD_SEQ) |=> RELAY_ON == $past(LOAD_SW))
    else $error("relay not following switch");
  stored_range_a: assert property (ON_PHASE <= 9'h167 && OFF_PHASE <= 9'h167 && ON_CYCLES >= 16'h0004)
    else $error("stored setting out of range");
  cancel_keep_a: assert property (KEY_CANCEL |=> !ENTRY_ACTIVE && $stable(ON_CYCLES) && $stable(ON_PHASE))
    else $error("cancel altered setting");
  cover property (TRACE_TRIG);
  cover property ($rose(RELAY_ON));
  cover property ($fell(ENTRY_ACTIVE));
endmodule
bind ipc_sequencer ipc_props u_ipc_props (.*);
`default_nettype wire

// file: verification/ipc_load_model.sv
// Supply zero crossings and a switched load drawing an inrush transient
`timescale 1ns/10ps
`default_nettype none
module ipc_load_model #(parameter int PERIOD = 360, parameter int INRUSH = 1000) (
  input  wire logic          clk,
  input  wire logic          run,
  input  wire logic          relay_on,
  output logic               zc_rise,
  output logic               zc_fall,
  output logic               smp_valid,
  output logic signed [15:0] smp
);
  int   ph = 0;
  logic relay_q = 1'b0;
  logic inr = 1'b0;
  // Samples kept off boundary cycles so a half-cycle owns each one
  always @(negedge clk)
  begin
    ph <= run ? (ph + 1) % PERIOD : 0;
    zc_rise <= run && ph == 0;
    zc_fall <= run && ph == PERIOD / 2;
    smp_valid <= run && ph % 4 == 2;
    relay_q <= relay_on;
    if (relay_on && !relay_q)
      inr <= 1'b1;
    else if (ph == 0 || ph == PERIOD / 2)
      inr <= 1'b0;
    smp <= !relay_on ? 16'sh0 : inr ? 16'(INRUSH) : (ph < PERIOD / 2 ? 16'sh28 : -16'sh28);
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the inrush peak capture sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CORE_CLK = 0, RST_N = 0, START_KEY = 0, MODE_INRUSH = 0, RANGE_UP = 0, RANGE_DN = 0;
  logic TRIG_INRUSH = 0, LOAD_SEQ = 0, LOAD_SW = 0, KEY_DIGIT = 0, KEY_MINUS = 0;
  logic KEY_ENTER = 0, KEY_CANCEL = 0, run = 0, bv = 0, pv, rq;
  logic [1:0] FIELD_SEL = 0;
  logic [3:0] KEY_VAL = 0;
  logic signed [15:0] bs = 0, ps;
  wire SAMPLE_VALID = run ? pv : bv;
  wire signed [15:0] SAMPLE = run ? ps : bs;
  wire ZC_RISE, ZC_FALL, AUTO_RANGE_EN, TRACE_TRIG, RELAY_ON, ENTRY_ACTIVE;
  wire signed [15:0] LAT_POS, LAT_NEG, HI_POS, HI_NEG;
  wire [1:0]  RANGE_SEL;
  wire [15:0] ON_CYCLES, OFF_CYCLES;
  wire [8:0]  ON_PHASE, OFF_PHASE;
  int err_count = 0, samples_checked = 0, cyc = 0, hp = 0, hn = 0, lp = 0, ln = 0;
  int nr = 0, nt = 0, zc = 0, v;
  int st[4] = '{50, 250, 0, 0};
  int tbl[9][4] = '{'{0,0,3,0}, '{0,0,4,0}, '{1,0,65535,0}, '{1,0,4,0}, '{2,1,90,0},
                    '{2,1,720,0}, '{3,0,999,0}, '{3,0,12,1}, '{0,0,7,1}};
  ipc_sequencer u_ipc_sequencer (.*);
  ipc_load_model u_ipc_load_model (.clk(CORE_CLK), .run(run), .relay_on(RELAY_ON),
    .zc_rise(ZC_RISE), .zc_fall(ZC_FALL), .smp_valid(pv), .smp(ps));
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(input logic [15:0] got, input int exp);
    samples_checked++;
    if (got !== 16'(exp))
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, 16'(exp));
    end
  endtask
  task automatic peaks;
    chk(LAT_POS, lp);
    chk(LAT_NEG, ln);
    chk(HI_POS, hp);
    chk(HI_NEG, hn);
  endtask
  task automatic rnd(input int n);
    repeat (n)
    begin
      @(negedge CORE_CLK);
      v = int'($urandom % 4001) - 2000;
      bv = 1;
      bs = 16'(v);
      lp = v > lp ? v : lp;
      ln = v < ln ? v : ln;
      hp = v > hp ? v : hp;
      hn = v < hn ? v : hn;
    end
    @(negedge CORE_CLK) bv = 0;
    @(negedge CORE_CLK);
  endtask
  task automatic ent(input int f, ng, val, cx);
    string s;
    s = $sformatf("%0d", val);
    @(negedge CORE_CLK);
    FIELD_SEL = 2'(f);
    if (ng)
    begin
      KEY_MINUS = 1;
      @(negedge CORE_CLK);
      KEY_MINUS = 0;
    end
    for (int i = 0; i < s.len(); i++)
    begin
      KEY_DIGIT = 1;
      KEY_VAL = 4'(s[i] - "0");
      @(negedge CORE_CLK);
      chk(ENTRY_ACTIVE, 1);
    end
    KEY_DIGIT = 0;
    KEY_ENTER = 1'(!cx);
    KEY_CANCEL = 1'(cx);
    @(negedge CORE_CLK);
    KEY_ENTER = 0;
    KEY_CANCEL = 0;
    @(negedge CORE_CLK);
    if (!cx && f < 2 && val >= 4) st[f] = val;
    if (!cx && f >= 2) st[f] = (ng && val % 360) ? 360 - val % 360 : val % 360;
    chk(ON_CYCLES, st[0]);
    chk(OFF_CYCLES, st[1]);
    chk(ON_PHASE, st[2]);
    chk(OFF_PHASE, st[3]);
    chk(ENTRY_ACTIVE, 0);
  endtask
  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h0e90));
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK) RST_N = 1;
    chk(RANGE_SEL, 3);
    rnd(40);
    peaks;
    @(negedge CORE_CLK) {START_KEY, bv, bs} = {2'b11, 16'sh7fff};
    @(negedge CORE_CLK) {START_KEY, bv, lp, ln, hp, hn} = '0;
    @(negedge CORE_CLK);
    peaks;
    rnd(20);
    @(negedge CORE_CLK) MODE_INRUSH = 1;
    repeat (2) @(negedge CORE_CLK);
    chk(RANGE_SEL, 3);
    chk(AUTO_RANGE_EN, 0);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge CORE_CLK) RANGE_UP = 1;
      @(negedge CORE_CLK) RANGE_UP = 0;
      chk(RANGE_SEL, i < 3 ? 2 - i : 0);
    end
    @(negedge CORE_CLK) RANGE_DN = 1;
    @(negedge CORE_CLK) RANGE_DN = 0;
    chk(RANGE_SEL, 1);
    foreach (tbl[i]) ent(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
    {run, TRIG_INRUSH, rq} = 3'b110;
    repeat (1080) @(negedge CORE_CLK);
    LOAD_SEQ = 1;
    repeat (10800)
    begin
      @(negedge CORE_CLK);
      if (RELAY_ON && !rq) {nr, zc} = {nr + 1, 32'h0};
      if (!RELAY_ON && rq) chk(16'(zc), 4);
      zc += RELAY_ON && ZC_RISE;
      nt += TRACE_TRIG;
      rq = RELAY_ON;
    end
    chk(16'(nt), nr);
    chk(16'(nr), 4);
    hp = hp > 1000 ? hp : 1000;
    hn = hn < -40 ? hn : -40;
    chk(LAT_POS, 1000);
    chk(HI_POS, hp);
    chk(HI_NEG, hn);
    chk(LAT_NEG, -40);
    @(negedge CORE_CLK) {LOAD_SEQ, LOAD_SW} = 2'b01;
    repeat (2) @(negedge CORE_CLK);
    chk(RELAY_ON, 1);
    end_sim;
  end
endmodule
`default_nettype wire
